// File: shared/tac_pkg.sv
// Purpose: shared constants and types of the teleprinter autostart control
// Assumes: 50 MHz hclk, AHB-Lite register access
// Notes: timer figures in milliseconds, counted on a 1 ms tick
package tac_pkg;

	localparam int CLK_NS = 20;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;

	// Longest valid space and autostart qualify period (plain defaults)
	localparam int SPACE_MAX_MS = 150;
	localparam int AUTO_MS = 2000;
	// Motor delay and loop current hold, in seconds as given
	localparam int MOTOR_S = 50;
	localparam int MOTOR_MS = MOTOR_S * 1000;
	localparam int HOLD_S = 7;
	localparam int HOLD_MS = HOLD_S * 1000;

	localparam int TW = 16;
	localparam int FIFO_DEPTH = 2;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_SPACE = 8'h08;
	localparam logic [7:0] A_TIMER = 8'h0C;

	localparam int C_MODE = 0;
	localparam int C_REV = 2;
	localparam int C_CLR = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;

	typedef enum logic [1:0] {
		MODE_AUTO = 2'b00,
		MODE_RECV = 2'b01,
		MODE_STBY = 2'b10
	} tac_mode_t;

	typedef enum logic {
		ST_STBY = 1'b0,
		ST_RECV = 1'b1
	} tac_state_t;

	typedef enum logic [1:0] {
		M_ON = 2'b00,
		M_HOLD = 2'b01,
		M_OFF = 2'b10
	} tac_motor_t;

	typedef struct packed {
		logic drive;
		logic mark;
	} tac_loop_t;

	typedef struct packed {
		logic recv;
		logic stby;
		logic relay;
		logic display;
	} tac_panel_t;

endpackage

// File: verilog/tac_top.sv
// Purpose: standby/receive control with autostart, motor delay and loop hold
// Assumes: carrier, comparator and remote standby arrive asynchronously
// Notes: loop samples leave through a small buffer only when they change
// What this block does
// [RULE1] Time each space of the keying stream; flag spaces longer than valid.
// [RULE2] In standby the autostart timer runs only with carrier present and space length valid.
// [RULE3] Autostart timer held for full period issues a receive command.
// [RULE4] Without a full autostart period the logic stays in standby.
// [RULE5] Receive returns to standby only after a full period deactivated.
// [RULE6] Every receive to standby transition in autostart mode starts the motor delay timer.
// [RULE7] Motor delay requests turn-off after 50 seconds unless receive restarts.
// [RULE8] Decision follows keying selector and all timers plus remote standby.
// [RULE9] Receive passes keying to loop gate, lights receive lamp, energises relay.
// [RULE10] Standby sends steady mark to the teleprinter and lights standby lamp.
// [RULE11] Autostart not selected keeps the motor relay energised always.
// [RULE12] Autostart selected releases the relay when motor delay completes.
// [RULE13] Relay release requests space and starts the loop current hold timer.
// [RULE14] During the 7 second hold the loop gate still delivers mark.
// [RULE15] After the hold expires the loop gate delivers no current at all.
// [RULE16] Display enable follows the carrier detector.
// [RULE17] Reverse operation inverts the comparator output before control logic.
// [RULE18] Timers run off a prescaled tick, periods parameters, synchronous clear.
// [RULE19] Remote standby forces standby while it is active.
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module tac_top #(
	parameter int TICK_CYC = tac_pkg::TICK_CYC,
	parameter int SPACE_MAX_MS = tac_pkg::SPACE_MAX_MS,
	parameter int AUTO_MS = tac_pkg::AUTO_MS,
	parameter int MOTOR_MS = tac_pkg::MOTOR_MS,
	parameter int HOLD_MS = tac_pkg::HOLD_MS,
	parameter int FIFO_DEPTH = tac_pkg::FIFO_DEPTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic carrier_in,
	input wire logic comp_in,
	input wire logic remote_stby_in,
	output tac_pkg::tac_panel_t panel,
	output logic loop_valid,
	output tac_pkg::tac_loop_t loop_data,
	input wire logic loop_ready
);
	import tac_pkg::*;

	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam logic [TW-1:0] SPACE_MAX = TW'(SPACE_MAX_MS);
	localparam logic [TW-1:0] AUTO_LAST = TW'(AUTO_MS - 1);
	localparam logic [TW-1:0] MOTOR_LAST = TW'(MOTOR_MS - 1);
	localparam logic [TW-1:0] HOLD_LAST = TW'(HOLD_MS - 1);
	localparam logic [TW-1:0] TW_MAX = {TW{1'b1}};
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

	// Pin synchronisers: carrier, comparator, remote standby
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {remote_stby_in, comp_in, carrier_in};
			sync2_reg <= sync1_reg;
		end
	end
	logic carrier;
	logic rstby;
	logic keying;
	logic [3:0] ctrl_reg;
	assign carrier = sync2_reg[0];
	assign rstby = sync2_reg[2];
	// Comparator high means mark tone
	assign keying = sync2_reg[1] ^ ctrl_reg[C_REV]; // [RULE17]

	tac_mode_t mode;
	logic clr;
	assign mode = tac_mode_t'(ctrl_reg[C_MODE +: 2]);
	assign clr = ctrl_reg[C_CLR];

	// AHB-Lite slave, zero wait states
	logic a_wr_reg;
	logic a_wr_next;
	logic [7:0] a_addr_reg;
	logic [7:0] a_addr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [3:0] ctrl_next;
	logic [31:0] status_word;
	logic [31:0] space_word;
	logic [31:0] timer_word;
	logic take;

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [3:0] c, input logic [31:0] s,
		input logic [31:0] sp, input logic [31:0] t);
		case (a)
			A_CTRL: rd_mux = {28'h0, c};
			A_STAT: rd_mux = s;
			A_SPACE: rd_mux = sp;
			A_TIMER: rd_mux = t;
			default: rd_mux = 32'h0;
		endcase
	endfunction

	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	always_comb begin
		a_wr_next = take && hwrite;
		a_addr_next = take ? haddr[7:0] : a_addr_reg;
		rdata_next = rdata_reg;
		if (take && !hwrite) begin
			rdata_next = rd_mux(haddr[7:0], ctrl_reg, status_word, space_word, timer_word);
		end
		// Clear bit self-clears: one synchronous clear pulse per write
		ctrl_next = {1'b0, ctrl_reg[2:0]};
		if (a_wr_reg && a_addr_reg == A_CTRL) begin
			ctrl_next = hwdata[3:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr_reg <= 1'b0;
			a_addr_reg <= 8'h0;
			rdata_reg <= 32'h0;
			ctrl_reg <= CTRL_RST;
		end else begin
			a_wr_reg <= a_wr_next;
			a_addr_reg <= a_addr_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
		end
	end

	// Millisecond tick; all second-scale timing counts it
	logic [31:0] pre_reg;
	logic [31:0] pre_next;
	logic tick;
	assign tick = (pre_reg == TICK_LAST);
	always_comb begin
		pre_next = tick ? 32'h0 : pre_reg + 32'h1;
		if (clr) begin
			pre_next = 32'h0; // [RULE18]
		end
	end

	// Space timer, autostart timer, state, motor delay and loop hold
	logic [TW-1:0] space_reg;
	logic [TW-1:0] space_next;
	logic [TW-1:0] auto_reg;
	logic [TW-1:0] auto_next;
	logic [TW-1:0] mcnt_reg;
	logic [TW-1:0] mcnt_next;
	logic mrun_reg;
	logic mrun_next;
	tac_state_t state_reg;
	tac_state_t state_next;
	tac_motor_t mtr_reg;
	tac_motor_t mtr_next;
	logic space_long;
	logic qualify;
	logic auto_done;
	logic go_stby;

	assign space_long = (space_reg > SPACE_MAX); // [RULE1]
	assign qualify = carrier && !space_long; // [RULE2]
	// In standby the timer counts activated time, in receive deactivated time
	assign auto_done = tick && (auto_reg == AUTO_LAST);
	assign go_stby = (state_reg == ST_RECV) && (state_next == ST_STBY);

	always_comb begin
		space_next = space_reg;
		if (keying) begin
			space_next = '0; // [RULE1]
		end else if (tick && space_reg != TW_MAX) begin
			space_next = space_reg + TW'(1);
		end
		auto_next = auto_reg;
		if ((state_reg == ST_STBY) != qualify) begin
			auto_next = '0; // [RULE2]
		end else if (auto_done) begin
			auto_next = '0;
		end else if (tick) begin
			auto_next = auto_reg + TW'(1);
		end
		state_next = state_reg;
		if (rstby || mode == MODE_STBY) begin
			state_next = ST_STBY; // [RULE19]
		end else if (mode == MODE_RECV) begin
			state_next = ST_RECV; // [RULE8]
		end else if (auto_done && (state_reg == ST_STBY) == qualify) begin
			// [RULE3] [RULE4] [RULE5]
			state_next = (state_reg == ST_STBY) ? ST_RECV : ST_STBY;
		end
		mrun_next = mrun_reg;
		mcnt_next = mcnt_reg;
		mtr_next = mtr_reg;
		if (state_next == ST_RECV || mode != MODE_AUTO) begin
			// [RULE7] [RULE11]
			mtr_next = M_ON;
			mrun_next = 1'b0;
			mcnt_next = '0;
		end else if (go_stby) begin
			mrun_next = 1'b1; // [RULE6]
			mcnt_next = '0;
		end else begin
			case (mtr_reg)
				M_ON: begin
					if (mrun_reg && tick) begin
						if (mcnt_reg == MOTOR_LAST) begin
							// [RULE12] [RULE13]
							mtr_next = M_HOLD;
							mrun_next = 1'b0;
							mcnt_next = '0;
						end else begin
							mcnt_next = mcnt_reg + TW'(1); // [RULE7]
						end
					end
				end
				M_HOLD: begin
					if (tick) begin
						if (mcnt_reg == HOLD_LAST) begin
							mtr_next = M_OFF; // [RULE15]
							mcnt_next = '0;
						end else begin
							mcnt_next = mcnt_reg + TW'(1); // [RULE14]
						end
					end
				end
				M_OFF: begin
					mtr_next = M_OFF;
				end
				default: begin
					mtr_next = M_OFF;
				end
			endcase
		end
		if (clr) begin
			// [RULE18]
			space_next = '0;
			auto_next = '0;
			mcnt_next = '0;
		end
	end

	// Loop gate: what the selector magnet driver is to see
	tac_loop_t smp;
	logic space_req;
	// Relay released asks for space; hold keeps mark until the timer ends
	assign space_req = (mtr_reg != M_ON); // [RULE13]
	always_comb begin
		smp.drive = 1'b1;
		smp.mark = 1'b1; // [RULE10] [RULE14]
		if (state_reg == ST_RECV) begin
			smp.mark = keying; // [RULE9]
		end else if (space_req && mtr_reg == M_OFF) begin
			smp.drive = 1'b0; // [RULE15]
			smp.mark = 1'b0;
		end
	end

	tac_panel_t panel_next;
	always_comb begin
		panel_next.recv = (state_reg == ST_RECV); // [RULE9]
		panel_next.stby = (state_reg == ST_STBY); // [RULE10]
		panel_next.relay = (mtr_reg == M_ON); // [RULE11] [RULE12]
		panel_next.display = carrier; // [RULE16]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_reg <= 32'h0;
			space_reg <= '0;
			auto_reg <= '0;
			mcnt_reg <= '0;
			mrun_reg <= 1'b0;
			state_reg <= ST_STBY;
			mtr_reg <= M_OFF;
			panel <= '0;
		end else begin
			pre_reg <= pre_next;
			space_reg <= space_next;
			auto_reg <= auto_next;
			mcnt_reg <= mcnt_next;
			mrun_reg <= mrun_next;
			state_reg <= state_next;
			mtr_reg <= mtr_next;
			panel <= panel_next;
		end
	end

	assign status_word = {24'h0, space_long, qualify, rstby, carrier, mrun_reg, mtr_reg, state_reg};
	assign space_word = {{(32 - TW){1'b0}}, space_reg};
	assign timer_word = {auto_reg, mcnt_reg};

	// Two-entry buffer toward the magnet driver; a change is retried while full
	tac_loop_t mem_reg [FIFO_DEPTH];
	tac_loop_t mem_next [FIFO_DEPTH];
	tac_loop_t last_reg;
	tac_loop_t last_next;
	logic [PW-1:0] wp_reg;
	logic [PW-1:0] wp_next;
	logic [PW-1:0] rp_reg;
	logic [PW-1:0] rp_next;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic full;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign full = (cnt_reg == CW'(FIFO_DEPTH));
	assign loop_valid = (cnt_reg != '0);
	assign loop_data = mem_reg[rp_reg];
	assign pop = loop_valid && loop_ready;
	assign push = (smp != last_reg) && !full;

	always_comb begin
		mem_next = mem_reg;
		last_next = last_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		if (push) begin
			mem_next[wp_reg] = smp;
			last_next = smp;
			wp_next = ptr_inc(wp_reg);
		end
		if (pop) begin
			rp_next = ptr_inc(rp_reg);
		end
		cnt_next = cnt_reg + CW'(push) - CW'(pop);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
			last_reg <= '0;
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			mem_reg <= mem_next;
			last_reg <= last_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_SPACE_RESET: assert property (keying && !clr |=> space_reg == '0) // [RULE1]
		else $error("space timer not cleared by mark");
	AST_QUALIFY: assert property ((state_reg == ST_STBY) && !qualify |=> auto_reg == '0) // [RULE2]
		else $error("autostart timer ran without qualify");
	AST_RECV_CMD: assert property (state_reg == ST_STBY && qualify && auto_done && mode == MODE_AUTO && !rstby
		|=> state_reg == ST_RECV) // [RULE3]
		else $error("no receive after full autostart period");
	AST_STAY_STBY: assert property (state_reg == ST_STBY && !auto_done && mode == MODE_AUTO
		|=> state_reg == ST_STBY) // [RULE4]
		else $error("left standby early");
	AST_STAY_RECV: assert property (state_reg == ST_RECV && qualify && mode == MODE_AUTO && !rstby
		|=> state_reg == ST_RECV) // [RULE5]
		else $error("left receive while qualified");
	AST_MOTOR_START: assert property (state_reg == ST_RECV && mode == MODE_AUTO && rstby
		|=> mrun_reg && mcnt_reg == '0) // [RULE6]
		else $error("motor delay not started");
	AST_RELAY_MANUAL: assert property (mode != MODE_AUTO |=> ##1 panel.relay) // [RULE11]
		else $error("relay released outside autostart");
	AST_RECV_KEY: assert property (state_reg == ST_RECV |-> smp.drive && smp.mark == keying) // [RULE9]
		else $error("keying not passed in receive");
	AST_STBY_MARK: assert property (state_reg == ST_STBY && mtr_reg != M_OFF |-> smp.drive && smp.mark) // [RULE10]
		else $error("standby not marking");
	AST_RELEASE: assert property (mtr_reg == M_ON && $past(mtr_reg) == M_ON ##1 mtr_reg == M_HOLD
		|-> mcnt_reg == '0 && smp.mark) // [RULE13]
		else $error("hold not started at release");
	AST_NO_CURRENT: assert property (mtr_reg == M_OFF && state_reg == ST_STBY |-> !smp.drive) // [RULE15]
		else $error("current after hold");
	AST_REMOTE: assert property (rstby |=> state_reg == ST_STBY) // [RULE19]
		else $error("remote standby ignored");
	AST_DISPLAY: assert property (panel.display == $past(carrier)) // [RULE16]
		else $error("display not following carrier");
	AST_FIFO_FULL: assert property (full |-> !push)
		else $error("push into full buffer");

endmodule

// File: verif/tac_loop_model.sv
// Purpose: selector magnet driver model that takes the loop stream
// Assumes: head entry taken at a rising edge with valid and ready high
// Notes: keeps the last three entries and a count for the bench
`timescale 1ns/10ps
module tac_loop_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic loop_valid,
	input wire tac_pkg::tac_loop_t loop_data,
	input wire logic stall,
	input wire logic slow,
	output logic loop_ready,
	output logic [5:0] hist,
	output logic [15:0] cnt
);
	import tac_pkg::*;
	// Slow mode answers every other cycle, to stretch the drain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loop_ready <= 1'b0;
			hist <= 6'h00;
			cnt <= 16'h0000;
		end else begin
			loop_ready <= !stall && !(slow && loop_ready);
			if (loop_valid && loop_ready) begin
				hist <= {hist[3:0], loop_data};
				cnt <= cnt + 16'h0001;
			end
		end
	end
endmodule

// File: verif/test_tac_top.sv
// Purpose: self-checking bench of the autostart control
// Assumes: short tick and periods so the run stays brief
// Notes: every wait is bounded; a spent bound ends the run
`timescale 1ns/10ps
module test_tac_top;
	import tac_pkg::*;
	localparam int TK = 10;
	localparam int AU = 3;
	localparam int SP = 4;
	localparam int MO = 6;
	localparam int HO = 4;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic carrier_in = 1'b0;
	logic comp_in = 1'b1;
	logic remote_stby_in = 1'b0;
	tac_panel_t panel;
	logic loop_valid;
	tac_loop_t loop_data;
	logic loop_ready;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic [5:0] hist;
	logic [15:0] cnt;
	logic [10:0] obs;
	int fail_count = 0;
	int compares = 0;
	// Panel in bits 3:0, valid in 4, accepted loop entries above
	assign obs = {hist, loop_valid, panel};
	tac_top #(.TICK_CYC(TK), .SPACE_MAX_MS(SP), .AUTO_MS(AU), .MOTOR_MS(MO), .HOLD_MS(HO), .FIFO_DEPTH(2)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.carrier_in(carrier_in), .comp_in(comp_in), .remote_stby_in(remote_stby_in), .panel(panel),
		.loop_valid(loop_valid), .loop_data(loop_data), .loop_ready(loop_ready));
	tac_loop_model model (.hclk(hclk), .hresetn(hresetn), .loop_valid(loop_valid), .loop_data(loop_data),
		.stall(stall), .slow(slow), .loop_ready(loop_ready), .hist(hist), .cnt(cnt));
	initial begin
		forever #10 hclk = ~hclk;
	end
	task automatic end_sim();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Sampled mid-cycle so registered outputs have settled
	task automatic look(input logic [10:0] mask, input logic [10:0] exp);
		@(negedge hclk);
		chk(obs & mask, exp);
		@(posedge hclk);
	endtask
	// Arrival earlier than lo is a mismatch as well as a late one
	task automatic wait_obs(input int i, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
			if (n > hi) begin
				fail_count++;
				end_sim();
			end
		end while (obs[i] !== v);
		chk(n >= lo, 1'b1);
		@(posedge hclk);
	endtask
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (n > 50) begin
				fail_count++;
				end_sim();
			end
		end while (hready !== 1'b1);
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		ahb(1'b0, a, 32'h00000000, q);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		look(11'h7FF, 11'h004);
		rd(A_CTRL, q);
		chk(q, 32'h00000000);
		// Response must stay OKAY
		chk({31'h0, hresp}, 32'h00000000);
		wr(A_STAT, 32'h000000FF);
		rd(A_STAT, q);
		chk(q & 32'h00000001, 32'h00000000);
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10, q);
		chk(q, 32'h00000000);
	endtask
	task automatic t_auto();
		carrier_in <= 1'b1;
		comp_in <= 1'b1;
		wait_obs(3, 1'b1, (AU - 1) * TK, (AU + 1) * TK + 8);
		cyc(6);
		look(11'h07F, 11'h06B);
	endtask
	// Receiver stalls so the two entries fill and a third must wait
	task automatic t_buf();
		logic [15:0] c0;
		c0 = cnt;
		stall <= 1'b1;
		cyc(2);
		comp_in <= 1'b0;
		cyc(6);
		comp_in <= 1'b1;
		cyc(6);
		comp_in <= 1'b0;
		cyc(8);
		look(11'h010, 11'h010);
		chk(cnt, c0);
		stall <= 1'b0;
		slow <= 1'b1;
		cyc(14);
		look(11'h7F0, 11'h5C0);
		chk(cnt - c0, 16'h0003);
		slow <= 1'b0;
		comp_in <= 1'b1;
		cyc(6);
	endtask
	task automatic t_stby();
		logic [31:0] q;
		comp_in <= 1'b0;
		wait_obs(2, 1'b1, (SP + AU - 2) * TK, (SP + AU + 2) * TK + 8);
		cyc(4);
		look(11'h07F, 11'h067);
		rd(A_STAT, q);
		chk(q & 32'h000000DF, 32'h00000098);
		wait_obs(1, 1'b0, (MO - 2) * TK, (MO + 1) * TK + 8);
		look(11'h060, 11'h060);
		rd(A_STAT, q);
		chk(q & 32'h00000006, 32'h00000002);
		wait_obs(6, 1'b0, (HO - 2) * TK, (HO + 1) * TK + 10);
		look(11'h7E0, 11'h580);
	endtask
	task automatic t_remote();
		logic [31:0] q;
		comp_in <= 1'b1;
		wait_obs(3, 1'b1, (AU - 1) * TK, (AU + 1) * TK + 8);
		remote_stby_in <= 1'b1;
		wait_obs(2, 1'b1, 0, 8);
		cyc((AU + 2) * TK);
		look(11'h00E, 11'h006);
		rd(A_STAT, q);
		chk(q & 32'h00000021, 32'h00000020);
		remote_stby_in <= 1'b0;
		wait_obs(3, 1'b1, 0, (AU + 1) * TK + 8);
		look(11'h00E, 11'h00A);
	endtask
	task automatic t_modes();
		logic [31:0] q;
		wr(A_CTRL, 32'h00000002);
		wait_obs(2, 1'b1, 0, 8);
		cyc((MO + 2) * TK);
		look(11'h00E, 11'h006);
		wr(A_CTRL, 32'h00000005);
		wait_obs(3, 1'b1, 0, 8);
		cyc(8);
		look(11'h060, 11'h040);
		rd(A_CTRL, q);
		chk(q, 32'h00000005);
		cyc(5 * TK);
		rd(A_SPACE, q);
		chk(q >= SP, 1'b1);
		wr(A_CTRL, 32'h0000000D);
		// Clear pulse acts one edge after the write lands
		cyc(1);
		rd(A_SPACE, q);
		chk(q, 32'h00000000);
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		cyc(2);
		t_reset();
		t_auto();
		t_buf();
		t_stby();
		t_remote();
		t_modes();
		end_sim();
	end
endmodule
